// >>> sync_interface_select_control.sv
// interface and sync source selection control register bank
`timescale 1ns/100ps
`include "sync_select_map.svh"
module sync_interface_select_control
  import sync_select_pkg::*;
#(
  parameter int THRESH_WIDTH = 8
)(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [7:0] address,
  input  wire logic [7:0] write_data,
  input  wire logic       write_strobe,
  input  wire logic       read_strobe,
  output logic [7:0]      read_data,
  input  wire logic       hsync_present,
  input  wire logic       sog_present,
  input  wire logic       vsync_present,
  input  wire logic       dclk_present,
  input  wire logic       auto_interface,
  input  wire logic       auto_hsync_source,
  input  wire logic       hsync_pin,
  input  wire logic       sog_sync,
  input  wire logic       vsync_pin,
  input  wire logic       hold_pin,
  output logic            current_interface_status,
  output logic            current_hsync_source_status,
  output logic            current_vsync_source_status,
  output logic            active_hsync,
  output logic            vsync_out,
  output logic            pll_hold,
  output logic            chip_sleep_n,
  output logic            irq
);
  reg_byte_t control;
  reg_byte_t threshold;
  reg_byte_t irq_status;
  reg_byte_t irq_mask;
  reg_byte_t status;
  reg_byte_t next_events;
  logic      sep_vsync;
  logic      sel_if;
  logic      sel_hs;
  logic      sel_vs;
  logic      auto_vs;
  logic      both_if;
  logic      both_hs;
  logic [3:0] det_last;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      control <= `RST_CONTROL;
    else if (write_strobe && hit(address, `OFS_CONTROL))
      control <= write_data;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      threshold <= `RST_THRESHOLD;
    else if (write_strobe && hit(address, `OFS_THRESHOLD))
      threshold <= write_data;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      irq_mask <= `RST_IRQ_MASK;
    else if (write_strobe && hit(address, `OFS_IRQ_MASK))
      irq_mask <= write_data;
  end

  sync_separator #(
    .WIDTH     (THRESH_WIDTH)
  ) u_sep (
    .clock     (clock),
    .rstn      (rstn),
    .sync_in   (vsync_pin),
    .threshold (threshold[THRESH_WIDTH-1:0]),
    .sep_vsync (sep_vsync)
  );

  assign both_if = (hsync_present || sog_present) && dclk_present;
  assign both_hs = hsync_present && sog_present;
  // automatic vsync: separator only when no vsync pin activity is seen
  assign auto_vs = !vsync_present;

  sync_source_mux u_if (
    .override     (control[`BIT_IF_OVERRIDE]),
    .choice       (control[`BIT_IF_CHOICE]),
    .both_present (both_if),
    .auto_status  (auto_interface),
    .selected     (sel_if)
  );

  sync_source_mux u_hs (
    .override     (control[`BIT_HS_OVERRIDE]),
    .choice       (control[`BIT_HS_CHOICE]),
    .both_present (both_hs),
    .auto_status  (auto_hsync_source),
    .selected     (sel_hs)
  );

  sync_source_mux u_vs (
    .override     (control[`BIT_VS_OVERRIDE]),
    .choice       (control[`BIT_VS_CHOICE]),
    .both_present (1'b0),
    .auto_status  (auto_vs),
    .selected     (sel_vs)
  );

  // data outputs registered; one cycle of latency after a select change
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      current_interface_status    <= 1'b0;
      current_hsync_source_status <= 1'b0;
      current_vsync_source_status <= 1'b0;
      active_hsync                <= 1'b0;
      vsync_out                   <= 1'b0;
      pll_hold                    <= 1'b0;
      chip_sleep_n                <= 1'b0;
    end
    else
    begin
      current_interface_status    <= sel_if;
      current_hsync_source_status <= sel_hs;
      current_vsync_source_status <= sel_vs;
      active_hsync <= sel_hs ? sog_sync : hsync_pin;
      vsync_out    <= sel_vs ? sep_vsync : vsync_pin;
      pll_hold     <= control[`BIT_HOLD_CHOICE] ?
                      vsync_out : hold_pin;
      chip_sleep_n <= control[`BIT_SLEEP_N];
    end
  end

  always_comb
  begin
    status = 8'h00;
    status[`ST_HS_DET]   = hsync_present;
    status[`ST_SOG_DET]  = sog_present;
    status[`ST_VS_DET]   = vsync_present;
    status[`ST_DCLK_DET] = dclk_present;
    status[`ST_IF]       = current_interface_status;
    status[`ST_HS_SRC]   = current_hsync_source_status;
    status[`ST_VS_SRC]   = current_vsync_source_status;
  end

  // events: rising edge of any detect bit, so hot plugging is seen
  always_comb
  begin
    next_events = 8'h00;
    next_events[3:0] = {hsync_present, sog_present, vsync_present,
                        dclk_present} & ~det_last;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      det_last <= 4'h0;
    else
      det_last <= {hsync_present, sog_present, vsync_present, dclk_present};
  end

  // read clears, but a same-cycle event still sets
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      irq_status <= 8'h00;
    else if (read_strobe && hit(address, `OFS_IRQ_STATUS))
      irq_status <= next_events;
    else
      irq_status <= irq_status | next_events;
  end

  assign irq = |(irq_status & irq_mask);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      read_data <= 8'h00;
    else if (read_strobe)
    begin
      unique case (address)
        `OFS_STATUS:     read_data <= status;
        `OFS_CONTROL:    read_data <= control;
        `OFS_THRESHOLD:  read_data <= threshold;
        `OFS_IRQ_STATUS: read_data <= irq_status;
        `OFS_IRQ_MASK:   read_data <= irq_mask;
        default:         read_data <= 8'h00;
      endcase
    end
    else
      read_data <= 8'h00;
  end

  a_if_override: assert property (@(posedge clock) disable iff (!rstn)
    control[`BIT_IF_OVERRIDE] |=>
      current_interface_status == $past(control[`BIT_IF_CHOICE]))
    else $error("interface override ignored");
  a_if_auto: assert property (@(posedge clock) disable iff (!rstn)
    (!control[`BIT_IF_OVERRIDE] && !both_if) |=>
      current_interface_status == $past(auto_interface))
    else $error("interface not following status");
  a_if_both: assert property (@(posedge clock) disable iff (!rstn)
    both_if |=> current_interface_status == $past(control[`BIT_IF_CHOICE]))
    else $error("interface choice not applied");
  a_hs_route: assert property (@(posedge clock) disable iff (!rstn)
    (control[`BIT_HS_OVERRIDE] || both_hs) |=>
      active_hsync == ($past(control[`BIT_HS_CHOICE]) ?
                       $past(sog_sync) : $past(hsync_pin)))
    else $error("hsync route wrong");
  a_hs_auto: assert property (@(posedge clock) disable iff (!rstn)
    (!control[`BIT_HS_OVERRIDE] && !both_hs) |=>
      current_hsync_source_status == $past(auto_hsync_source))
    else $error("hsync not following status");
  a_vs_route: assert property (@(posedge clock) disable iff (!rstn)
    control[`BIT_VS_OVERRIDE] |=>
      vsync_out == ($past(control[`BIT_VS_CHOICE]) ?
                    $past(sep_vsync) : $past(vsync_pin)))
    else $error("vsync route wrong");
  a_hold_route: assert property (@(posedge clock) disable iff (!rstn)
    !control[`BIT_HOLD_CHOICE] |=> pll_hold == $past(hold_pin))
    else $error("hold pin not routed");
  a_sleep_bit: assert property (@(posedge clock) disable iff (!rstn)
    (write_strobe && address == `OFS_CONTROL) ##1 1'b1 |=>
      chip_sleep_n == $past(control[`BIT_SLEEP_N]))
    else $error("power down bit not applied");
  a_det_read: assert property (@(posedge clock) disable iff (!rstn)
    (read_strobe && address == `OFS_STATUS) |=>
      read_data[`ST_DCLK_DET] == $past(dclk_present))
    else $error("detect bit misread");

  c_override: cover property (@(posedge clock) disable iff (!rstn)
    control[`BIT_IF_OVERRIDE] && control[`BIT_IF_CHOICE]);
  c_both_hs: cover property (@(posedge clock) disable iff (!rstn)
    both_hs && control[`BIT_HS_CHOICE]);
  c_sleep: cover property (@(posedge clock) disable iff (!rstn)
    !chip_sleep_n ##1 chip_sleep_n);
  c_irq: cover property (@(posedge clock) disable iff (!rstn) irq);
endmodule // sync_interface_select_control

// >>> sync_select_map.svh
// register offsets, field positions and reset values
`ifndef SYNC_SELECT_MAP_SVH
`define SYNC_SELECT_MAP_SVH
`define OFS_STATUS        8'h11
`define OFS_CONTROL       8'h12
`define OFS_THRESHOLD     8'h13
`define OFS_IRQ_STATUS    8'h14
`define OFS_IRQ_MASK      8'h15
`define BIT_IF_OVERRIDE   7
`define BIT_IF_CHOICE     6
`define BIT_HS_OVERRIDE   5
`define BIT_HS_CHOICE     4
`define BIT_VS_OVERRIDE   3
`define BIT_VS_CHOICE     2
`define BIT_HOLD_CHOICE   1
`define BIT_SLEEP_N       0
`define ST_HS_DET         7
`define ST_SOG_DET        6
`define ST_VS_DET         5
`define ST_DCLK_DET       4
`define ST_IF             3
`define ST_HS_SRC         2
`define ST_VS_SRC         1
`define RST_CONTROL       8'h01
`define RST_THRESHOLD     8'h20
`define RST_IRQ_MASK      8'h00
`endif

// >>> sync_select_pkg.sv
// types shared by the interface and sync source selection block
package sync_select_pkg;
  typedef enum logic [1:0] {sep_idle, sep_count} sep_state_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// >>> sync_separator.sv
// sync separator: recovers vsync from a composite sync by pulse width
`timescale 1ns/100ps
`include "sync_select_map.svh"
module sync_separator
  import sync_select_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             sync_in,
  input  wire logic [WIDTH-1:0] threshold,
  output logic                  sep_vsync
);
  logic [WIDTH-1:0] count;
  logic             last;

  // counter restarts on every edge, so only long pulses reach the threshold
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= '0;
      last  <= 1'b0;
    end
    else
    begin
      last <= sync_in;
      if (sync_in != last)
        count <= '0;
      // saturate at the threshold so a lowered threshold never wraps round
      else if (count < threshold)
        count <= count + 1'b1;
    end
  end

  // output follows the input level once it has lasted threshold clocks
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      sep_vsync <= 1'b0;
    else if (sync_in == last && count >= threshold)
      sep_vsync <= sync_in;
  end

  a_sep_follows: assert property (@(posedge clock) disable iff (!rstn)
    (sync_in == last && count >= threshold) |=> sep_vsync == $past(sync_in))
    else $error("separator did not toggle at threshold");
endmodule // sync_separator

// >>> sync_source_mux.sv
// source choice: override bit or both sources present picks software select, else automatic status
`timescale 1ns/100ps
module sync_source_mux
(
  input  wire logic override,
  input  wire logic choice,
  input  wire logic both_present,
  input  wire logic auto_status,
  output logic      selected
);
  // software choice wins when forced, or when both sources are present
  always_comb
  begin
    if (override || both_present)
      selected = choice;
    else
      selected = auto_status;
  end
endmodule // sync_source_mux

// >>> sync_interface_select_control_bench.sv
// self-checking bench for the interface and sync source selection bank
`timescale 1ns/100ps
module sync_interface_select_control_bench;
  import sync_select_pkg::*;
  logic       clock;
  logic       rstn;
  logic [7:0] address;
  logic [7:0] write_data;
  logic       write_strobe;
  logic       read_strobe;
  logic [7:0] read_data;
  logic       hsync_present;
  logic       sog_present;
  logic       vsync_present;
  logic       dclk_present;
  logic       auto_interface;
  logic       auto_hsync_source;
  logic       hsync_pin;
  logic       sog_sync;
  logic       vsync_pin;
  logic       hold_pin;
  logic       current_interface_status;
  logic       current_hsync_source_status;
  logic       current_vsync_source_status;
  logic       active_hsync;
  logic       vsync_out;
  logic       pll_hold;
  logic       chip_sleep_n;
  logic       irq;
  int         n_fail;
  int         checks_done;
  int         cycles;
  logic [7:0] rd_val;

  sync_interface_select_control #(.THRESH_WIDTH(8))
  sync_interface_select_control_inst
  (
    .clock                       (clock),
    .rstn                        (rstn),
    .address                     (address),
    .write_data                  (write_data),
    .write_strobe                (write_strobe),
    .read_strobe                 (read_strobe),
    .read_data                   (read_data),
    .hsync_present               (hsync_present),
    .sog_present                 (sog_present),
    .vsync_present               (vsync_present),
    .dclk_present                (dclk_present),
    .auto_interface              (auto_interface),
    .auto_hsync_source           (auto_hsync_source),
    .hsync_pin                   (hsync_pin),
    .sog_sync                    (sog_sync),
    .vsync_pin                   (vsync_pin),
    .hold_pin                    (hold_pin),
    .current_interface_status    (current_interface_status),
    .current_hsync_source_status (current_hsync_source_status),
    .current_vsync_source_status (current_vsync_source_status),
    .active_hsync                (active_hsync),
    .vsync_out                   (vsync_out),
    .pll_hold                    (pll_hold),
    .chip_sleep_n                (chip_sleep_n),
    .irq                         (irq)
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task complete_run;
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // a hang would otherwise never reach the verdict
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    address      <= a;
    write_data   <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    address     <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 d = read_data;
  endtask

  task settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  initial
  begin
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    rstn = 1'b0;
    {address, write_data, write_strobe, read_strobe} = '0;
    {hsync_present, sog_present, vsync_present, dclk_present} = '0;
    {auto_interface, auto_hsync_source, sog_sync, vsync_pin} = '0;
    hsync_pin = 1'b1;
    hold_pin = 1'b0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    rd(`OFS_CONTROL, rd_val); check(rd_val, `RST_CONTROL);
    check({7'h00, chip_sleep_n}, 8'h01);
    rd(`OFS_THRESHOLD, rd_val); check(rd_val, `RST_THRESHOLD);
    rd(`OFS_IRQ_MASK, rd_val); check(rd_val, `RST_IRQ_MASK);
    rd(8'h3c, rd_val); check(rd_val, 8'h00);
    rd(`OFS_IRQ_STATUS, rd_val);
    // interrupt: sticky detect event, masked, then unmasked, read clears
    dclk_present <= 1'b1;
    settle(4); check({7'h00, irq}, 8'h00);
    wr(`OFS_IRQ_MASK, 8'h01);
    settle(2); check({7'h00, irq}, 8'h01);
    rd(`OFS_IRQ_STATUS, rd_val); check(rd_val, 8'h01);
    settle(2); check({7'h00, irq}, 8'h00);
    wr(`OFS_STATUS, 8'hff);
    rd(`OFS_STATUS, rd_val); check(rd_val, 8'h12);
    // active interface: forced, automatic, both present
    wr(`OFS_CONTROL, 8'hc1);
    settle(3); check({7'h00, current_interface_status}, 8'h01);
    auto_interface <= 1'b1;
    wr(`OFS_CONTROL, 8'h81);
    settle(3); check({7'h00, current_interface_status}, 8'h00);
    wr(`OFS_CONTROL, 8'h01);
    settle(3); check({7'h00, current_interface_status}, 8'h01);
    auto_interface <= 1'b0;
    hsync_present <= 1'b1;
    wr(`OFS_CONTROL, 8'h41);
    settle(3); check({7'h00, current_interface_status}, 8'h01);
    hsync_present <= 1'b0;
    settle(3); check({7'h00, current_interface_status}, 8'h00);
    // hsync source: forced sog, forced pin, both detected, automatic
    wr(`OFS_CONTROL, 8'h31);
    settle(3); check({6'h00, current_hsync_source_status, active_hsync},
                     8'h02);
    wr(`OFS_CONTROL, 8'h21);
    settle(3); check({6'h00, current_hsync_source_status, active_hsync},
                     8'h01);
    hsync_present <= 1'b1;
    sog_present   <= 1'b1;
    wr(`OFS_CONTROL, 8'h11);
    settle(3); check({7'h00, current_hsync_source_status}, 8'h01);
    sog_present <= 1'b0;
    settle(3); check({7'h00, current_hsync_source_status}, 8'h00);
    // raw vsync forced, hold from pin then from vsync
    vsync_pin <= 1'b1;
    hold_pin  <= 1'b1;
    wr(`OFS_CONTROL, 8'h09);
    settle(4); check({6'h00, current_vsync_source_status, vsync_out},
                     8'h01);
    check({7'h00, pll_hold}, 8'h01);
    hold_pin <= 1'b0;
    settle(4); check({7'h00, pll_hold}, 8'h00);
    wr(`OFS_CONTROL, 8'h0b);
    settle(4); check({7'h00, pll_hold}, 8'h01);
    // separated vsync waits for the threshold, ignores short pulses
    wr(`OFS_THRESHOLD, 8'h04);
    wr(`OFS_CONTROL, 8'h0d);
    settle(12); check({7'h00, vsync_out}, 8'h01);
    vsync_pin <= 1'b0;
    settle(3); check({7'h00, vsync_out}, 8'h01);
    settle(9); check({6'h00, current_vsync_source_status, vsync_out},
                     8'h02);
    vsync_pin <= 1'b1;
    settle(2);
    vsync_pin <= 1'b0;
    settle(12); check({7'h00, vsync_out}, 8'h00);
    // automatic vsync source follows the vsync detector
    vsync_present <= 1'b1;
    wr(`OFS_CONTROL, 8'h01);
    settle(4); check({7'h00, current_vsync_source_status}, 8'h00);
    vsync_present <= 1'b0;
    settle(4); check({7'h00, current_vsync_source_status}, 8'h01);
    // full chip sleep is active low
    wr(`OFS_CONTROL, 8'h00);
    settle(2); check({7'h00, chip_sleep_n}, 8'h00);
    wr(`OFS_CONTROL, 8'h01);
    settle(2); check({7'h00, chip_sleep_n}, 8'h01);
    complete_run;
  end
endmodule // sync_interface_select_control_bench
